// ==== src/pendant_pkg.sv ====
// Shared constants, types and helpers for the manual pendant front end
package pendant_pkg;

    // Clock and debounce timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int DEBOUNCE_US     = 2000;
    localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int DB_CNT_W        = 17;
    localparam logic [1:0] BOARD_SETTLE = 2'h3;

    // Register byte offsets
    localparam logic [11:0] OFS_STATUS     = 12'h000;
    localparam logic [11:0] OFS_IN_ASSIGN  = 12'h004;
    localparam logic [11:0] OFS_OUT_ASSIGN = 12'h008;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h00c;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h010;
    localparam logic [3:0]  PARAM_PAGE     = 4'h1;

    // Values after reset
    localparam logic [31:0] IN_ASSIGN_RST  = 32'h0000_0000;
    localparam logic [15:0] OUT_ASSIGN_RST = 16'h5410;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

    // Input assignment field: 8 bits per general input
    localparam int IN_FIELD_W = 8;
    localparam int IN_EN_POS  = 0;
    localparam int IN_FN_POS  = 1;
    localparam int IN_AX_POS  = 3;
    // Output assignment field: 4 bits per general output
    localparam int OUT_FIELD_W = 4;
    localparam int OUT_AX_POS  = 0;
    localparam int OUT_SRC_POS = 2;

    // Status register field positions
    localparam int ST_MANUAL = 0;
    localparam int ST_ESTOP  = 1;
    localparam int ST_AXIS   = 2;
    localparam int ST_AXOK   = 4;
    localparam int ST_BOARD  = 8;
    localparam int ST_RUN    = 12;
    localparam int ST_CCW    = 16;

    // Interrupt bits
    localparam int IRQ_ESTOP = 0;
    localparam int IRQ_MODE  = 1;
    localparam int IRQ_SCAN  = 2;

    typedef enum logic [1:0] {
        FN_PAUSE    = 2'h0,
        FN_SPEED0   = 2'h1,
        FN_SPEED1   = 2'h2,
        FN_SLOWDOWN = 2'h3
    } in_func_e;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_FETCH = 3'b010,
        BUS_REPLY = 3'b100
    } bus_state_e;

    // Parameter slot indices within one axis
    localparam logic [3:0] P_START       = 4'h0;
    localparam logic [3:0] P_TOP         = 4'h1;
    localparam logic [3:0] P_END         = 4'h2;
    localparam logic [3:0] P_ACCEL       = 4'h3;
    localparam logic [3:0] P_DECEL       = 4'h4;
    localparam logic [3:0] P_END_PULSE   = 4'h5;
    localparam logic [3:0] P_SLOW        = 4'h6;
    localparam logic [3:0] P_SLOW_DELAY  = 4'h7;
    localparam logic [3:0] P_SCAN_START  = 4'h8;
    localparam logic [3:0] P_SCAN_TOP    = 4'h9;
    localparam logic [3:0] P_SCAN_END    = 4'ha;
    localparam logic [3:0] P_SCAN_ACCEL  = 4'hb;
    localparam logic [3:0] P_SCAN_DECEL  = 4'hc;
    localparam logic [3:0] P_SCAN_AREA   = 4'hd;
    localparam logic [3:0] P_SCAN_SLOW   = 4'he;
    localparam logic [3:0] P_HOMING      = 4'hf;

    // Jumper defaults
    localparam logic [15:0] SPD_LOW_FIT  = 16'h012c;
    localparam logic [15:0] SPD_LOW_OPEN = 16'h0320;
    localparam logic [15:0] SPD_TOP_FIT  = 16'h0bb8;
    localparam logic [15:0] SPD_TOP_OPEN = 16'h2710;
    localparam logic [15:0] RATE_FIT     = 16'h0018;
    localparam logic [15:0] RATE_OPEN    = 16'h0025;
    localparam logic [15:0] AREA_FIT     = 16'h0014;
    localparam logic [15:0] AREA_OPEN    = 16'h003c;
    localparam logic [15:0] PARAM_ZERO   = 16'h0000;

    // Default value of a slot for a fitted or open jumper
    function automatic logic [15:0] param_default(input logic [3:0] idx,
                                                  input logic       fitted);
        logic [15:0] v;
        v = PARAM_ZERO;
        case (idx)
            P_START, P_END, P_SLOW, P_SCAN_START, P_SCAN_END, P_SCAN_SLOW,
            P_HOMING:
                v = fitted ? SPD_LOW_FIT : SPD_LOW_OPEN;
            P_TOP, P_SCAN_TOP:
                v = fitted ? SPD_TOP_FIT : SPD_TOP_OPEN;
            P_ACCEL, P_DECEL, P_SCAN_ACCEL, P_SCAN_DECEL:
                v = fitted ? RATE_FIT : RATE_OPEN;
            P_SCAN_AREA:
                v = fitted ? AREA_FIT : AREA_OPEN;
            default:
                v = PARAM_ZERO;
        endcase
        return v;
    endfunction : param_default

    // Lowest-numbered low select line wins; bit 2 flags a valid pick
    function automatic logic [2:0] decode_axis(input logic [3:0] sel_n);
        logic [2:0] r;
        r = 3'h0;
        if (!sel_n[0]) r = 3'h4;
        else if (!sel_n[1]) r = 3'h5;
        else if (!sel_n[2]) r = 3'h6;
        else if (!sel_n[3]) r = 3'h7;
        return r;
    endfunction : decode_axis

endpackage : pendant_pkg

// ==== src/param_if.sv ====
// Carrier between the front end and its parameter memory
`timescale 1ns/1ns
interface param_if;
    logic        we;
    logic [5:0]  waddr;
    logic [15:0] wdata;
    logic [5:0]  raddr_a;
    logic [15:0] rdata_a;
    logic [5:0]  raddr_b;
    logic [15:0] rdata_b;

    modport mem  (input  we, waddr, wdata, raddr_a, raddr_b,
                  output rdata_a, rdata_b);
    modport user (output we, waddr, wdata, raddr_a, raddr_b,
                  input  rdata_a, rdata_b);
endinterface : param_if

// ==== src/param_mem.sv ====
// Two-read-port parameter store, 4 axes by 16 slots, registered reads
`timescale 1ns/1ns
module param_mem (
    input  wire logic clk_i,  // System clock
    param_if.mem      pm      // Memory side of the carrier
);
    logic [15:0] store [64];

    // Contents carry no reset; validity is tracked by the user
    always_ff @(posedge clk_i) begin
        if (pm.we) begin
            store[pm.waddr] <= pm.wdata;
        end
        pm.rdata_a <= store[pm.raddr_a];
        pm.rdata_b <= store[pm.raddr_b];
    end
endmodule : param_mem

// ==== src/manual_scan_pendant_control.sv ====
// Manual pendant front end with mode, scan, input and output routing
`timescale 1ns/1ns
module manual_scan_pendant_control
    import pendant_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES  // Debounce sample period
) (
    input  wire logic        clk_i,                  // 50 MHz clock
    input  wire logic        rst_i,                  // Sync reset, high
    input  wire logic        wb_cyc_i,               // Wishbone cycle
    input  wire logic        wb_stb_i,               // Wishbone strobe
    input  wire logic        wb_we_i,                // Wishbone write
    input  wire logic [11:0] wb_adr_i,               // Byte address
    input  wire logic [3:0]  wb_sel_i,               // Byte lanes
    input  wire logic [31:0] wb_dat_i,               // Write data
    output logic      [31:0] wb_dat_o,               // Read data
    output logic             wb_ack_o,               // Acknowledge
    output logic             irq_o,                  // Level interrupt
    input  wire logic        manual_select_i,        // Pendant mode pin
    input  wire logic        emergency_stop_second_n_i, // Stop, low active
    input  wire logic        scan_cw_request_n_i,    // CW scan, low active
    input  wire logic        scan_ccw_request_n_i,   // CCW scan, low active
    input  wire logic [3:0]  general_in_n_i,         // General / select pins
    input  wire logic [3:0]  default_param_jumper_i, // 1 = jumper fitted
    input  wire logic [3:0]  board_number_switch_i,  // Rotary switch
    input  wire logic [3:0]  counter_event_i,        // Per-axis counter event
    input  wire logic [3:0]  second_event_i,         // Per-axis second event
    input  wire logic [3:0]  param_idx_i,            // Scan engine slot pick
    output logic      [15:0] param_val_o,            // Effective param value
    output logic             stop_all_o,             // Halt all pulse output
    output logic      [3:0]  scan_run_o,             // Per-axis scan active
    output logic      [3:0]  scan_ccw_o,             // Per-axis scan is CCW
    output logic      [3:0]  pause_o,                // Per-axis pause
    output logic      [3:0]  speed_choice_0_o,       // Per-axis speed bit 0
    output logic      [3:0]  speed_choice_1_o,       // Per-axis speed bit 1
    output logic      [3:0]  slowdown_halt_o,        // Per-axis slow stop
    output logic      [3:0]  general_out_o,          // Routed event outputs
    output logic      [3:0]  board_number_o,         // Captured board number
    output logic      [2:0]  manual_axis_o           // Bit 2 valid, axis
);
    // Per-axis mask of inputs doing one function
    function automatic logic [3:0] fn_axes(input logic [31:0] asg,
                                           input logic [3:0]  act,
                                           input logic [1:0]  fn);
        logic [3:0] r;
        logic [7:0] f;
        r = 4'h0;
        for (int i = 0; i < 4; i++) begin
            f = asg[i*IN_FIELD_W +: IN_FIELD_W];
            if (f[IN_EN_POS] && f[IN_FN_POS +: 2] == fn && act[i]) begin
                r[f[IN_AX_POS +: 2]] = 1'b1;
            end
        end
        return r;
    endfunction : fn_axes
    // Byte-lane merge for control registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction : lane_merge
    param_if pm ();
    param_mem u_mem (.clk_i(clk_i), .pm(pm));
    // Two-stage synchronisers for every pin input
    logic [15:0] sync_a_reg;
    logic [15:0] sync_b_reg;
    wire  [15:0] pins = {board_number_switch_i, default_param_jumper_i,
                         general_in_n_i, scan_ccw_request_n_i,
                         scan_cw_request_n_i, manual_select_i,
                         emergency_stop_second_n_i};
    always_ff @(posedge clk_i) begin
        sync_a_reg <= pins;
        sync_b_reg <= sync_a_reg;
    end
    wire       estop_n_s = sync_b_reg[0];
    wire [6:0] db_raw    = sync_b_reg[7:1];
    wire [3:0] jumper_s  = sync_b_reg[11:8];
    wire [3:0] board_s   = sync_b_reg[15:12];
    // Shared sample tick; a level is taken after two equal samples
    logic [DB_CNT_W-1:0] db_cnt_reg;
    logic [6:0]          db_prev_reg;
    logic [6:0]          db_reg;
    wire db_tick = (db_cnt_reg == DB_CNT_W'(DEBOUNCE_LEN - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            db_cnt_reg  <= '0;
            db_prev_reg <= 7'h7f;
            db_reg      <= 7'h7f;
        end else begin
            db_cnt_reg <= db_tick ? '0 : db_cnt_reg + 1'b1;
            if (db_tick) begin
                db_prev_reg <= db_raw;
                if (db_raw == db_prev_reg) db_reg <= db_raw;
            end
        end
    end
    // Fixed levels: no polarity option on these seven pins
    wire       man_host = db_reg[0];
    wire       cw_n     = db_reg[1];
    wire       ccw_n    = db_reg[2];
    wire [3:0] gin_n    = db_reg[6:3];
    // Mode and axis selection
    wire       manual_mode = !man_host;
    wire [2:0] axis_pick   = decode_axis(gin_n);
    // Scan requests; both pressed together is treated as no request
    logic [3:0] scan_run_next;
    logic [3:0] scan_ccw_next;
    wire scan_ok = manual_mode && estop_n_s && axis_pick[2] && (cw_n ^ ccw_n);
    always_comb begin
        scan_run_next = 4'h0;
        scan_ccw_next = 4'h0;
        if (scan_ok) begin
            scan_run_next[axis_pick[1:0]] = 1'b1;
            scan_ccw_next[axis_pick[1:0]] = !ccw_n;
        end
    end
    // Control registers
    logic [31:0] in_assign_reg;
    logic [15:0] out_assign_reg;
    logic [2:0]  irq_status_reg;
    logic [2:0]  irq_mask_reg;
    logic [63:0] written_reg;
    bus_state_e  bus_state_reg;
    // Bus decode
    wire req      = wb_cyc_i && wb_stb_i;
    wire hit_st   = (wb_adr_i == OFS_STATUS);
    wire hit_in   = (wb_adr_i == OFS_IN_ASSIGN);
    wire hit_out  = (wb_adr_i == OFS_OUT_ASSIGN);
    wire hit_irq  = (wb_adr_i == OFS_IRQ_STATUS);
    wire hit_msk  = (wb_adr_i == OFS_IRQ_MASK);
    wire hit_par  = (wb_adr_i[11:8] == PARAM_PAGE) && (wb_adr_i[1:0] == 2'h0);
    wire [5:0] par_a = wb_adr_i[7:2];
    wire fetch    = (bus_state_reg == BUS_FETCH) && req;
    wire wr_now   = fetch && wb_we_i;
    wire rd_now   = fetch && !wb_we_i;
    // Effective value: host-written slot or jumper default
    wire [15:0] par_eff_a = written_reg[par_a] ? pm.rdata_a :
                            param_default(par_a[3:0], jumper_s[par_a[5:4]]);
    logic [5:0] raddr_b_reg;
    wire  [15:0] par_eff_b = written_reg[raddr_b_reg] ? pm.rdata_b :
                  param_default(raddr_b_reg[3:0], jumper_s[raddr_b_reg[5:4]]);
    // Memory hookup; only full low-half writes reach a slot
    assign pm.we      = wr_now && hit_par && (wb_sel_i[1:0] == 2'h3);
    assign pm.waddr   = par_a;
    assign pm.wdata   = wb_dat_i[15:0];
    assign pm.raddr_a = par_a;
    assign pm.raddr_b = {axis_pick[1:0], param_idx_i};
    wire [31:0] status_word = (32'h0
        | (32'(manual_mode)      << ST_MANUAL)
        | (32'(!estop_n_s)       << ST_ESTOP)
        | (32'(axis_pick[1:0])   << ST_AXIS)
        | (32'(axis_pick[2])     << ST_AXOK)
        | (32'(board_number_o)   << ST_BOARD)
        | (32'(scan_run_o)       << ST_RUN)
        | (32'(scan_ccw_o)       << ST_CCW));
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_st) rd_mux = status_word;
        else if (hit_in) rd_mux = in_assign_reg;
        else if (hit_out) rd_mux = {16'h0, out_assign_reg};
        else if (hit_irq) rd_mux = {29'h0, irq_status_reg};
        else if (hit_msk) rd_mux = {29'h0, irq_mask_reg};
        else if (hit_par) rd_mux = {16'h0, par_eff_a};
    end
    // Bus sequencer: one cycle for the memory read, then a one-cycle ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_reg <= BUS_IDLE;
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0;
        end else begin
            wb_ack_o <= 1'b0;
            case (bus_state_reg)
                BUS_IDLE:  if (req) bus_state_reg <= BUS_FETCH;
                BUS_FETCH: begin
                    bus_state_reg <= req ? BUS_REPLY : BUS_IDLE;
                    wb_ack_o      <= req;
                    wb_dat_o      <= wb_we_i ? 32'h0 : rd_mux;
                end
                BUS_REPLY: bus_state_reg <= BUS_IDLE;
                default:   bus_state_reg <= BUS_IDLE;
            endcase
        end
    end
    // Register writes and the written-slot flags
    wire [31:0] out_merged = lane_merge({16'h0, out_assign_reg}, wb_dat_i,
                                        wb_sel_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_assign_reg  <= IN_ASSIGN_RST;
            out_assign_reg <= OUT_ASSIGN_RST;
            irq_mask_reg   <= IRQ_MASK_RST;
            written_reg    <= '0;
        end else if (wr_now) begin
            if (hit_in) in_assign_reg <= lane_merge(in_assign_reg, wb_dat_i,
                                                    wb_sel_i);
            if (hit_out) out_assign_reg <= out_merged[15:0];
            if (hit_msk && wb_sel_i[0]) irq_mask_reg <= wb_dat_i[2:0];
            if (pm.we) written_reg[par_a] <= 1'b1;
        end
    end
    // Events; a new event beats a read clear in the same cycle
    logic estop_prev_reg;
    logic man_prev_reg;
    wire [2:0] irq_ev = {(scan_run_next != 4'h0) && (scan_run_o == 4'h0),
                         man_host != man_prev_reg,
                         estop_prev_reg && !estop_n_s};
    wire rd_clear = rd_now && hit_irq;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            estop_prev_reg <= 1'b1;
            man_prev_reg   <= 1'b1;
            irq_status_reg <= 3'h0;
            irq_o          <= 1'b0;
        end else begin
            estop_prev_reg <= estop_n_s;
            man_prev_reg   <= man_host;
            irq_status_reg <= (rd_clear ? 3'h0 : irq_status_reg) | irq_ev;
            irq_o          <= |(irq_status_reg & irq_mask_reg);
        end
    end
    // Host-mode functions from general inputs, silenced in manual mode
    wire [3:0] gin_act = ~gin_n;
    always_ff @(posedge clk_i) begin
        if (rst_i || manual_mode) begin
            pause_o          <= 4'h0;
            speed_choice_0_o <= 4'h0;
            speed_choice_1_o <= 4'h0;
            slowdown_halt_o  <= 4'h0;
        end else begin
            pause_o          <= fn_axes(in_assign_reg, gin_act, FN_PAUSE);
            speed_choice_0_o <= fn_axes(in_assign_reg, gin_act, FN_SPEED0);
            speed_choice_1_o <= fn_axes(in_assign_reg, gin_act, FN_SPEED1);
            slowdown_halt_o  <= fn_axes(in_assign_reg, gin_act, FN_SLOWDOWN);
        end
    end
    // Scan outputs, stop, routed outputs and the scan parameter port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_all_o    <= 1'b0;
            scan_run_o    <= 4'h0;
            scan_ccw_o    <= 4'h0;
            general_out_o <= 4'h0;
            manual_axis_o <= 3'h0;
            raddr_b_reg   <= 6'h0;
            param_val_o   <= 16'h0;
        end else begin
            stop_all_o    <= !estop_n_s;
            scan_run_o    <= scan_run_next;
            scan_ccw_o    <= scan_ccw_next;
            manual_axis_o <= manual_mode ? axis_pick : 3'h0;
            raddr_b_reg   <= pm.raddr_b;
            param_val_o   <= par_eff_b;
            for (int k = 0; k < 4; k++) begin
                general_out_o[k] <=
                  out_assign_reg[k*OUT_FIELD_W + OUT_SRC_POS] ?
                  second_event_i[out_assign_reg[k*OUT_FIELD_W+OUT_AX_POS+:2]] :
                  counter_event_i[out_assign_reg[k*OUT_FIELD_W+OUT_AX_POS+:2]];
            end
        end
    end
    // Board number taken once, a few cycles after reset release
    logic [1:0] board_wait_reg;
    logic       board_taken_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            board_wait_reg  <= 2'h0;
            board_taken_reg <= 1'b0;
            board_number_o  <= 4'h0;
        end else if (!board_taken_reg) begin
            board_wait_reg <= board_wait_reg + 1'b1;
            if (board_wait_reg == BOARD_SETTLE) begin
                board_taken_reg <= 1'b1;
                board_number_o  <= board_s;
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_estop_halts: assert property (
        !estop_n_s |=> stop_all_o && (scan_run_o == 4'h0))
        else $error("stop did not halt all axes");
    chk_host_no_scan: assert property (
        man_host |=> (scan_run_o == 4'h0))
        else $error("scan ran in host mode");
    chk_scan_axis: assert property (
        scan_ok && !cw_n |=> scan_run_o == (4'h1 << $past(axis_pick[1:0]))
                             && (scan_ccw_o == 4'h0))
        else $error("cw scan on wrong axis");
    chk_manual_mutes: assert property (
        manual_mode |=> (pause_o | speed_choice_0_o | speed_choice_1_o
                         | slowdown_halt_o) == 4'h0)
        else $error("input function active in manual mode");
    chk_in_reset: assert property (
        $fell(rst_i) |-> (in_assign_reg == IN_ASSIGN_RST))
        else $error("input assignment not cleared");
    chk_out_reset: assert property (
        $fell(rst_i) |-> (out_assign_reg == OUT_ASSIGN_RST))
        else $error("output routing reset wrong");
    chk_board_held: assert property (
        board_taken_reg && $past(board_taken_reg) |-> $stable(board_number_o))
        else $error("board number changed after capture");
    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    chk_default_param: assert property (
        !written_reg[raddr_b_reg] && raddr_b_reg[3:0] == P_TOP
        |=> param_val_o == ($past(jumper_s[raddr_b_reg[5:4]]) ?
                            SPD_TOP_FIT : SPD_TOP_OPEN))
        else $error("top speed default wrong");
    chk_rate_default: assert property (
        !written_reg[raddr_b_reg] && raddr_b_reg[3:0] == P_ACCEL
        |=> param_val_o == ($past(jumper_s[raddr_b_reg[5:4]]) ?
                            RATE_FIT : RATE_OPEN))
        else $error("rate default wrong");
endmodule : manual_scan_pendant_control

// ==== tb/pendant_model.sv ====
// Pendant model: operator keys to pin levels
`timescale 1ns/1ns
module pendant_model (
    input  wire logic       host_i,   // Mode key
    input  wire logic       stop_i,   // Stop key
    input  wire logic       cw_i,     // CW key
    input  wire logic       ccw_i,    // CCW key
    input  wire logic [3:0] sel_i,    // Axis keys
    output logic            man_o,    // Mode pin
    output logic            stop_n_o, // Stop pin
    output logic            cw_n_o,   // CW pin
    output logic            ccw_n_o,  // CCW pin
    output logic [3:0]      sel_n_o   // Select pins
);
    // Keys other than the mode key pull to ground, no polarity option
    assign man_o = host_i;
    assign stop_n_o = ~stop_i;
    assign cw_n_o = ~cw_i;
    assign ccw_n_o = ~ccw_i;
    assign sel_n_o = ~sel_i;
endmodule : pendant_model

// ==== tb/manual_scan_pendant_control_test.sv ====
// Bench for the manual pendant front end
`timescale 1ns/1ns
module manual_scan_pendant_control_test;
    import pendant_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, req = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hf, counter_event_i = 4'h0;
    logic [3:0] second_event_i = 4'h0, param_idx_i = 4'h0, sel_key = 4'h0;
    logic [3:0] default_param_jumper_i = 4'h1;
    logic [3:0] board_number_switch_i = 4'h5; // Distinct, nonzero
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, irq_o, stop_all_o, host_key = 1'b1, stop_key = 1'b0;
    logic cw_key = 1'b0, manual_select_i, emergency_stop_second_n_i;
    logic scan_cw_request_n_i, scan_ccw_request_n_i, ccw_key = 1'b0;
    logic [3:0] general_in_n_i, scan_run_o, scan_ccw_o, pause_o;
    logic [3:0] board_number_o, speed_choice_0_o, speed_choice_1_o;
    logic [3:0] slowdown_halt_o, general_out_o;
    logic [15:0] param_val_o;
    logic [2:0] manual_axis_o;
    int n_mismatch = 0, samples_checked = 0;
    always #10 clk_i = ~clk_i;
    // Short debounce keeps the run brief
    manual_scan_pendant_control #(.DEBOUNCE_LEN(4))
    u_manual_scan_pendant_control (
        .clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .manual_select_i,
        .emergency_stop_second_n_i, .scan_cw_request_n_i, .scan_ccw_request_n_i,
        .general_in_n_i, .default_param_jumper_i, .board_number_switch_i,
        .counter_event_i, .second_event_i, .param_idx_i, .param_val_o,
        .stop_all_o, .scan_run_o, .scan_ccw_o, .pause_o, .speed_choice_0_o,
        .speed_choice_1_o, .slowdown_halt_o, .general_out_o, .board_number_o,
        .manual_axis_o);
    pendant_model u_pendant_model (.host_i(host_key), .stop_i(stop_key),
        .cw_i(cw_key), .ccw_i(ccw_key), .sel_i(sel_key),
        .man_o(manual_select_i),
        .stop_n_o(emergency_stop_second_n_i), .cw_n_o(scan_cw_request_n_i),
        .ccw_n_o(scan_ccw_request_n_i), .sel_n_o(general_in_n_i));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string w, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    // Classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        req <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        @(posedge clk_i);
    endtask : bus
    task automatic t_outputs();
        bus(1'b0, OFS_OUT_ASSIGN, 32'h0);
        chk("out_asg", 32'h5410, rd);
        bus(1'b0, OFS_IN_ASSIGN, 32'h0);
        chk("in_asg", 32'h0, rd);
        bus(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, rd);
        counter_event_i <= 4'h3;
        second_event_i <= 4'h1;
        idle(3);
        chk("gen_out", 32'h7, {28'h0, general_out_o});
        bus(1'b1, OFS_OUT_ASSIGN, 32'h5416);
        counter_event_i <= 4'h0;
        second_event_i <= 4'h4;
        idle(3);
        chk("gen_moved", 32'h1, {28'h0, general_out_o});
        $display("t_outputs done");
    endtask : t_outputs
    task automatic t_params();
        logic [11:0] a [4] = '{12'h100, 12'h144, 12'h14c, 12'h134};
        logic [31:0] e [4] = '{32'h12c, 32'h2710, 32'h25, 32'h14};
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk("param", e[i], rd);
        end
        bus(1'b1, 12'h100, 32'h1234);
        bus(1'b0, 12'h100, 32'h0);
        chk("param_new", 32'h1234, rd);
        $display("t_params done");
    endtask : t_params
    task automatic t_modes();
        bus(1'b1, OFS_IN_ASSIGN, 32'h051b_0917);
        bus(1'b1, OFS_IRQ_MASK, 32'h6);
        sel_key <= 4'hf;
        cw_key <= 1'b1;
        idle(30); // Debounce settles well inside this
        chk("pause", 32'h2, {28'h0, pause_o});
        chk("slow", 32'h4, {28'h0, slowdown_halt_o});
        chk("spd0", 32'h8, {28'h0, speed_choice_0_o});
        chk("spd1", 32'h1, {28'h0, speed_choice_1_o});
        chk("host_run", 32'h0, {28'h0, scan_run_o});
        host_key <= 1'b0;
        sel_key <= 4'h2;
        idle(30);
        chk("pause_man", 32'h0, {28'h0, pause_o});
        chk("run", 32'h2, {28'h0, scan_run_o});
        chk("axis", 32'h5, {29'h0, manual_axis_o});
        chk("irq", 32'h1, {31'h0, irq_o});
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h2515, rd);
        cw_key <= 1'b0;
        ccw_key <= 1'b1;
        idle(30);
        chk("ccw", 32'h2, {28'h0, scan_ccw_o});
        cw_key <= 1'b1;
        idle(30);
        chk("both", 32'h0, {28'h0, scan_run_o});
        cw_key <= 1'b0;
        param_idx_i <= P_TOP;
        idle(30);
        chk("top_dflt", 32'h2710, {16'h0, param_val_o});
        param_idx_i <= P_ACCEL;
        idle(3);
        chk("rate_dflt", 32'h25, {16'h0, param_val_o});
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("irq_st", 32'h6, rd);
        idle(3);
        chk("irq_clr", 32'h0, {31'h0, irq_o});
        $display("t_modes done");
    endtask : t_modes
    task automatic t_stop();
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        stop_key <= 1'b1;
        board_number_switch_i <= 4'ha;
        idle(4);
        chk("stop_all", 32'h1, {31'h0, stop_all_o});
        idle(4);
        chk("run_off", 32'h0, {28'h0, scan_run_o});
        chk("masked", 32'h0, {31'h0, irq_o});
        chk("board", 32'h5, {28'h0, board_number_o});
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("stop_ev", 32'h1, rd);
        $display("t_stop done");
    endtask : t_stop
    initial begin
        idle(2);
        rst_i <= 1'b0;
        idle(6);
        t_outputs();
        t_params();
        t_modes();
        t_stop();
        tally_and_finish();
    end
endmodule : manual_scan_pendant_control_test
